// ### shared/isa_decode_pkg.sv
/*
 * constants and carrier types for the memory-mode address decode block
 * and its serial loader for the external upper-address decoder.
 * assumes a 20 MHz core clock and a 16-bit host register port.
 */
package isa_decode_pkg;
    // ==========================================================
    // register offsets
    localparam logic [11:0] OFS_IO_BASE = 12'h020;
    localparam logic [11:0] OFS_MEM_LOW = 12'h02C;
    localparam logic [11:0] OFS_MEM_HIGH = 12'h02E;
    localparam logic [11:0] OFS_EXT_PROG = 12'h040;
    localparam logic [11:0] OFS_HOST_BUS_CONTROL = 12'h044;
    localparam logic [11:0] OFS_STATUS = 12'h046;
    // ==========================================================
    // field positions
    localparam int BIT_MEM_ENABLE = 10;
    localparam int BIT_EXT_SELECT = 10;
    localparam int EXT_VALUE_W = 4;
    localparam int MEM_ADDR_W = 20;
    localparam int MEM_IGNORED_BITS = 12;
    localparam int IO_IGNORED_BITS = 4;
    localparam int STS_BUSY = 0;
    localparam int STS_EXT_PRESENT = 1;
    localparam int STS_ADDR_LOADED = 2;
    // ==========================================================
    // reset values
    localparam logic [15:0] IO_BASE_RESET = 16'h0300;
    localparam logic [15:0] REG_ZERO_RESET = 16'h0000;
    // ==========================================================
    // serial load frame: start bit, opcode, then the value msb first
    localparam logic START_BIT = 1'b1;
    localparam logic [4:0] PROGRAM_DISABLE_OPCODE = 5'h00;
    localparam int FRAME_BITS = 1 + 5 + EXT_VALUE_W;
    // ==========================================================
    // timing
    localparam int MCLK_PERIOD_NS = 50;
    localparam int SERIAL_BIT_NS = 1000;
    localparam int SERIAL_HALF_CYCLES_RAW = SERIAL_BIT_NS / MCLK_PERIOD_NS / 2;
    localparam int SERIAL_HALF_CYCLES = (SERIAL_HALF_CYCLES_RAW < 1) ? 1 : SERIAL_HALF_CYCLES_RAW;
    // ==========================================================
    // types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] offset;
        logic [15:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_CLK_LOW = 2'b01,
        SH_CLK_HIGH = 2'b10
    } shift_state_t;
endpackage

// ### testbench/isa_mem_decode_chk.sv
/* port assertions for isa_mem_decode.
   assumes the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module isa_mem_decode_chk import isa_decode_pkg::*; #(
    parameter int HALF_CYCLES = SERIAL_HALF_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_offset,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_io_cycle,
    input wire logic [15:0] i_io_addr,
    input wire logic o_io_claim,
    input wire logic i_mem_cycle,
    input wire logic [MEM_ADDR_W-1:0] i_mem_addr,
    input wire logic i_device_select_in_n,
    input wire logic o_mem_claim,
    input wire logic o_ext_logic_select_pin,
    input wire logic o_serial_mem_select,
    input wire logic o_serial_mem_clock,
    input wire logic o_serial_mem_data_out
);
    logic [15:0] io_b, m_lo, m_hi, ctl;
    int low_cnt;
    logic hit;
    // ==========
    // shadow registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            io_b <= IO_BASE_RESET;
            m_lo <= REG_ZERO_RESET;
            m_hi <= REG_ZERO_RESET;
            ctl <= REG_ZERO_RESET;
            low_cnt <= 0;
        end else begin
            if (i_reg_wr && i_reg_offset == OFS_IO_BASE) io_b <= i_reg_wdata;
            if (i_reg_wr && i_reg_offset == OFS_MEM_LOW) m_lo <= i_reg_wdata;
            if (i_reg_wr && i_reg_offset == OFS_MEM_HIGH) m_hi <= i_reg_wdata;
            if (i_reg_wr && i_reg_offset == OFS_HOST_BUS_CONTROL) ctl <= i_reg_wdata;
            low_cnt <= o_ext_logic_select_pin ? 0 : low_cnt + 1;
        end
    end
    assign hit = i_mem_cycle && ctl[BIT_MEM_ENABLE] && !i_device_select_in_n
        && i_mem_addr[19:12] == {m_hi[3:0], m_lo[15:12]};
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // assertions
    property p_mem_claim; o_mem_claim == $past(hit); endproperty
    a_mem_claim: assert property (p_mem_claim) else $error("mem claim");
    property p_desel; i_device_select_in_n |=> !o_mem_claim; endproperty
    a_desel: assert property (p_desel) else $error("claim deselected");
    property p_io; o_io_claim == $past(i_io_cycle && i_io_addr[15:4] == io_b[15:4]); endproperty
    a_io: assert property (p_io) else $error("io claim");
    property p_ser_sel; !o_serial_mem_select; endproperty
    a_ser_sel: assert property (p_ser_sel) else $error("serial select");
    property p_start; $fell(o_ext_logic_select_pin) |-> o_serial_mem_data_out; endproperty
    a_start: assert property (p_start) else $error("start bit");
    property p_len; $rose(o_ext_logic_select_pin) |-> low_cnt == FRAME_BITS*2*HALF_CYCLES;
    endproperty
    a_len: assert property (p_len) else $error("frame length");
    property p_idle; o_ext_logic_select_pin |-> !o_serial_mem_clock; endproperty
    a_idle: assert property (p_idle) else $error("clock idle");
    property p_hold;
        (o_serial_mem_clock && !o_ext_logic_select_pin) |=>
            (!o_serial_mem_clock || $stable(o_serial_mem_data_out));
    endproperty
    a_hold: assert property (p_hold) else $error("data hold");
endmodule
bind isa_mem_decode isa_mem_decode_chk #(.HALF_CYCLES(HALF_CYCLES)) chk (.i_mclk, .i_rst_n,
    .i_reg_wr, .i_reg_offset, .i_reg_wdata, .i_io_cycle, .i_io_addr, .o_io_claim,
    .i_mem_cycle, .i_mem_addr, .i_device_select_in_n, .o_mem_claim, .o_ext_logic_select_pin,
    .o_serial_mem_select, .o_serial_mem_clock, .o_serial_mem_data_out);
`default_nettype wire

// ### testbench/testbench.sv
/* self-checking bench for isa_mem_decode with decoder model.
   assumes the package and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench import isa_decode_pkg::*;;
    logic i_mclk, i_rst_n, rd, wr, ioc, mc, ale, strap, dsel_n, so, soe, ssel, sclk, sd;
    logic pres, ioclm, mclm, pin, valid, lowmem, far_sel_n;
    logic [11:0] off;
    logic [15:0] wd, rdata, ia, v;
    logic [19:0] ma;
    logic [3:0] la, q;
    int err_total, cmp_count, io_m, base_m, en_m, q_m, val_m;
    assign pin = soe ? so : strap;
    assign dsel_n = lowmem ? 1'b0 : far_sel_n;
    isa_mem_decode #(.HALF_CYCLES(2)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_offset(off), .i_reg_wdata(wd),
        .o_reg_rdata(rdata), .i_io_cycle(ioc), .i_io_addr(ia), .o_io_claim(ioclm),
        .i_mem_cycle(mc), .i_mem_addr(ma), .i_device_select_in_n(dsel_n),
        .o_mem_claim(mclm), .i_ext_logic_select_pin(pin), .o_ext_logic_select_pin(so),
        .o_ext_logic_select_pin_oe(soe), .o_serial_mem_select(ssel),
        .o_serial_mem_clock(sclk), .o_serial_mem_data_out(sd), .o_ext_logic_present(pres));
    upper_decoder_model far (.i_rst_n(i_rst_n), .i_sclk(sclk), .i_sdata(sd),
        .i_select_n(pin), .i_ale(ale), .i_la(la), .o_device_select_n(far_sel_n),
        .o_q(q), .o_valid(valid));
    always #25 i_mclk = ~i_mclk;
    // ==========
    // tasks
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wreg(logic [11:0] o, logic [15:0] d);
        @(posedge i_mclk) {wr, off, wd} <= {1'b1, o, d};
        @(posedge i_mclk) wr <= 1'b0;
    endtask
    task automatic rreg(logic [11:0] o, output logic [15:0] d);
        @(posedge i_mclk) {rd, off} <= {1'b1, o};
        @(posedge i_mclk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wt(logic lv);
        for (int i = 0; i < 500 && pin !== lv; i++) @(posedge i_mclk);
        if (pin !== lv) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic cyc(int n);
        logic [15:0] a;
        logic [19:0] m;
        logic [3:0] l;
        logic e;
        repeat (n) begin
            a = $urandom % 2 ? {io_m[15:4], 4'($urandom)} : 16'($urandom);
            m = $urandom % 2 ? {base_m[19:12], 12'($urandom)} : 20'($urandom);
            l = $urandom % 2 ? 4'(q_m) : 4'($urandom);
            e = en_m && (lowmem || (val_m && l == q_m)) && m[19:12] == base_m[19:12];
            @(posedge i_mclk) {ioc, mc, ale, ia, ma, la} <= {3'b111, a, m, l};
            @(posedge i_mclk) {ioc, mc, ale} <= 3'b000;
            #1;
            chk("io_claim", 16'(a[15:4] == io_m[15:4]), 16'(ioclm));
            chk("mem_claim", 16'(e), 16'(mclm));
        end
    endtask
    task automatic boot(logic s);
        {i_rst_n, strap, io_m, base_m, en_m, val_m} = {1'b0, s, 32'h300, 96'h0};
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
        rreg(OFS_STATUS, v);
        chk("status", {14'h0, s, 1'b0}, v);
        chk("present", 16'(s), 16'(pres));
    endtask
    // ==========
    // main sequence
    initial begin
        {i_mclk, rd, wr, ioc, mc, ale, lowmem, off, wd, ia, ma, la} = '0;
        {err_total, cmp_count, q_m} = '0;
        void'($urandom(32'h0854));
        boot(1'b1);
        rreg(OFS_IO_BASE, v);
        chk("io_base", IO_BASE_RESET, v);
        rreg(12'h0FE, v);
        chk("unmapped", 16'h0, v);
        cyc(20);
        wreg(OFS_EXT_PROG, 16'h040A);
        wt(1'b0);
        wreg(OFS_EXT_PROG, 16'h0405);
        wt(1'b1);
        repeat (2) @(posedge i_mclk);
        rreg(OFS_STATUS, v);
        chk("loaded", 16'h0006, v);
        chk("decoder", 16'h000A, {12'h0, q});
        chk("valid", 16'h0001, {15'h0, valid});
        rreg(OFS_EXT_PROG, v);
        chk("ext_prog", 16'h040A, v);
        wreg(OFS_EXT_PROG, 16'h0003);
        repeat (4) @(posedge i_mclk);
        rreg(OFS_STATUS, v);
        chk("no_load", 16'h0006, v);
        chk("held", 16'h000A, {12'h0, q});
        {q_m, val_m} = {32'hA, 32'h1};
        base_m = $urandom & 32'hFF000;
        wreg(OFS_MEM_LOW, base_m[15:0]);
        wreg(OFS_MEM_HIGH, {12'h0, base_m[19:16]});
        wreg(OFS_HOST_BUS_CONTROL, 16'h0400);
        en_m = 1;
        cyc(60);
        lowmem = 1'b1;
        cyc(20);
        lowmem = 1'b0;
        wreg(OFS_HOST_BUS_CONTROL, 16'h0);
        en_m = 0;
        cyc(10);
        boot(1'b0);
        wreg(OFS_HOST_BUS_CONTROL, 16'h0400);
        en_m = 1;
        cyc(10);
        give_verdict();
    end
endmodule
`default_nettype wire

// ### testbench/upper_decoder_model.sv
/* external upper-address decoder model.
   assumes the select pin wire and serial lines of the dut. */
`timescale 1ns/10ps
`default_nettype none
module upper_decoder_model (
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_select_n,
    input wire logic i_ale,
    input wire logic [3:0] i_la,
    output logic o_device_select_n,
    output logic [3:0] o_q,
    output logic o_valid
);
    logic shifted;
    // ==========
    // shift register, held while select high
    always @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= 4'h0;
            shifted <= 1'b0;
        end else if (!i_select_n) begin
            o_q <= {o_q[2:0], i_sdata};
            shifted <= 1'b1;
        end
    end
    always @(posedge i_select_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
        end else begin
            o_valid <= shifted;
        end
    end
    // ==========
    // compare while latch enable high, hold otherwise
    always_latch begin
        if (!i_rst_n) begin
            o_device_select_n = 1'b1;
        end else if (i_ale) begin
            o_device_select_n = !(o_valid && i_la == o_q);
        end
    end
endmodule
`default_nettype wire

// ### verilog/ext_decoder_loader.sv
/*
 * serial loader: shifts a start bit, the program-disable opcode and a
 * 4-bit upper-address value out on serial clock and data, holding the
 * external-logic select low for the whole frame.
 * assumes an asynchronous active-low reset already released cleanly.
 */
`timescale 1ns/10ps
`default_nettype none
module ext_decoder_loader import isa_decode_pkg::*; #(
    parameter int HALF_CYCLES = SERIAL_HALF_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [EXT_VALUE_W-1:0] i_value,
    output logic o_sclk,
    output logic o_sdata,
    output logic o_select_n,
    output logic o_busy,
    output logic o_done
);
    typedef struct packed {
        shift_state_t state;
        logic [7:0] div;
        logic [3:0] count;
        logic [FRAME_BITS-1:0] frame;
        logic sclk;
        logic sdata;
        logic select_n;
        logic done;
    } loader_state_t;

    localparam logic [7:0] DIV_LAST = 8'(HALF_CYCLES - 1);
    localparam logic [3:0] COUNT_LAST = 4'(FRAME_BITS - 1);

    loader_state_t st;
    loader_state_t next_st;

    // ==========================================================
    // frame sequencing
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            SH_IDLE: begin
                next_st.sclk = 1'b0;
                next_st.select_n = 1'b1;
                if (i_start) begin
                    next_st.frame = {START_BIT, PROGRAM_DISABLE_OPCODE, i_value};
                    next_st.state = SH_CLK_LOW;
                    next_st.div = 8'h00;
                    next_st.count = 4'h0;
                    next_st.select_n = 1'b0;
                    next_st.sdata = START_BIT;
                end
            end
            SH_CLK_LOW: begin
                next_st.sclk = 1'b0;
                next_st.sdata = st.frame[FRAME_BITS-1];
                if (st.div == DIV_LAST) begin
                    next_st.div = 8'h00;
                    next_st.sclk = 1'b1;
                    next_st.state = SH_CLK_HIGH;
                end else begin
                    next_st.div = st.div + 8'h01;
                end
            end
            SH_CLK_HIGH: begin
                if (st.div == DIV_LAST) begin
                    next_st.div = 8'h00;
                    next_st.sclk = 1'b0;
                    next_st.frame = {st.frame[FRAME_BITS-2:0], 1'b0};
                    if (st.count == COUNT_LAST) begin
                        next_st.state = SH_IDLE;
                        next_st.select_n = 1'b1;
                        next_st.done = 1'b1;
                    end else begin
                        next_st.count = st.count + 4'h1;
                        next_st.sdata = st.frame[FRAME_BITS-2];
                        next_st.state = SH_CLK_LOW;
                    end
                end else begin
                    next_st.div = st.div + 8'h01;
                end
            end
            default: begin
                next_st.state = SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '{state: SH_IDLE, div: 8'h00, count: 4'h0, frame: '0,
                    sclk: 1'b0, sdata: 1'b0, select_n: 1'b1, done: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_sclk = st.sclk;
    assign o_sdata = st.sdata;
    assign o_select_n = st.select_n;
    assign o_busy = (st.state != SH_IDLE);
    assign o_done = st.done;
endmodule
`default_nettype wire

// ### verilog/isa_mem_decode.sv
/*
 * memory-mode and i/o address decode of the bus interface, its host
 * registers, the reset-time strap of the external-logic select pin and
 * the loader for the external upper-address decoder.
 * assumes the host register port and bus cycle inputs are synchronous
 * to i_mclk; the external decoder shifts on rising serial clock.
 */
`timescale 1ns/10ps
`default_nettype none
module isa_mem_decode import isa_decode_pkg::*; #(
    parameter int HALF_CYCLES = SERIAL_HALF_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [11:0] i_reg_offset,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic i_io_cycle,
    input wire logic [15:0] i_io_addr,
    output logic o_io_claim,
    input wire logic i_mem_cycle,
    input wire logic [MEM_ADDR_W-1:0] i_mem_addr,
    input wire logic i_device_select_in_n,
    output logic o_mem_claim,
    input wire logic i_ext_logic_select_pin,
    output logic o_ext_logic_select_pin,
    output logic o_ext_logic_select_pin_oe,
    output logic o_serial_mem_select,
    output logic o_serial_mem_clock,
    output logic o_serial_mem_data_out,
    output logic o_ext_logic_present
);
    typedef struct packed {
        logic [15:0] io_base;
        logic [15:0] mem_low;
        logic [15:0] mem_high;
        logic [15:0] ext_prog;
        logic [15:0] host_bus_control;
        logic strap_done;
        logic ext_present;
        logic addr_loaded;
        logic start;
        logic [15:0] rdata;
        logic io_claim;
        logic mem_claim;
        logic pin_oe;
    } top_state_t;

    logic [1:0] rst_sync;
    logic rst_n;
    reg_req_t req;
    top_state_t st;
    top_state_t next_st;
    logic ld_busy;
    logic ld_done;
    logic ld_select_n;
    logic [MEM_ADDR_W-1:0] mem_base;

    // ==========================================================
    // reset release
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign req = '{wr: i_reg_wr, rd: i_reg_rd, offset: i_reg_offset, wdata: i_reg_wdata};
    assign mem_base = {st.mem_high[MEM_ADDR_W-17:0], st.mem_low};

    // ==========================================================
    // registers, decode and strap
    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.ext_present = i_ext_logic_select_pin;
        end
        next_st.pin_oe = st.strap_done;
        if (req.wr) begin
            case (req.offset)
                OFS_IO_BASE: next_st.io_base = req.wdata;
                OFS_MEM_LOW: next_st.mem_low = req.wdata;
                OFS_MEM_HIGH: next_st.mem_high = req.wdata;
                OFS_HOST_BUS_CONTROL: next_st.host_bus_control = req.wdata;
                OFS_EXT_PROG: begin
                    if (!ld_busy) begin
                        next_st.ext_prog = req.wdata;
                        if (req.wdata[BIT_EXT_SELECT]) begin
                            next_st.start = 1'b1;
                            next_st.addr_loaded = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // a finishing frame wins over a new load starting in the same cycle
        if (ld_done) begin
            next_st.addr_loaded = 1'b1;
        end
        if (req.rd) begin
            case (req.offset)
                OFS_IO_BASE: next_st.rdata = st.io_base;
                OFS_MEM_LOW: next_st.rdata = st.mem_low;
                OFS_MEM_HIGH: next_st.rdata = st.mem_high;
                OFS_EXT_PROG: next_st.rdata = st.ext_prog;
                OFS_HOST_BUS_CONTROL: next_st.rdata = st.host_bus_control;
                OFS_STATUS: begin
                    next_st.rdata = 16'h0000;
                    next_st.rdata[STS_BUSY] = ld_busy;
                    next_st.rdata[STS_EXT_PRESENT] = st.ext_present;
                    next_st.rdata[STS_ADDR_LOADED] = st.addr_loaded;
                end
                default: next_st.rdata = 16'h0000;
            endcase
        end
        next_st.io_claim = i_io_cycle
            && (i_io_addr[15:IO_IGNORED_BITS] == st.io_base[15:IO_IGNORED_BITS]);
        next_st.mem_claim = i_mem_cycle
            && st.host_bus_control[BIT_MEM_ENABLE]
            && !i_device_select_in_n
            && (i_mem_addr[MEM_ADDR_W-1:MEM_IGNORED_BITS]
                == mem_base[MEM_ADDR_W-1:MEM_IGNORED_BITS]);
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{io_base: IO_BASE_RESET, mem_low: REG_ZERO_RESET,
                    mem_high: REG_ZERO_RESET, ext_prog: REG_ZERO_RESET,
                    host_bus_control: REG_ZERO_RESET, strap_done: 1'b0, ext_present: 1'b0,
                    addr_loaded: 1'b0, start: 1'b0, rdata: 16'h0000,
                    io_claim: 1'b0, mem_claim: 1'b0, pin_oe: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // serial loader for the external decoder
    ext_decoder_loader #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_loader (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_start(st.start),
        .i_value(st.ext_prog[EXT_VALUE_W-1:0]),
        .o_sclk(o_serial_mem_clock),
        .o_sdata(o_serial_mem_data_out),
        .o_select_n(ld_select_n),
        .o_busy(ld_busy),
        .o_done(ld_done)
    );

    // ==========================================================
    // outputs
    assign o_reg_rdata = st.rdata;
    assign o_io_claim = st.io_claim;
    assign o_mem_claim = st.mem_claim;
    assign o_ext_logic_select_pin = ld_select_n;
    assign o_ext_logic_select_pin_oe = st.pin_oe;
    assign o_serial_mem_select = 1'b0;
    assign o_ext_logic_present = st.ext_present;
endmodule
`default_nettype wire
